// file: rtl/acs_cfg.svh
// register map, field positions, reset values and timing counts
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// ==================================================================
// register offsets (byte addresses, one word each)
`define ACS_ADDR_W      8
`define ACS_OFF_CTRL    8'h00
`define ACS_OFF_MODE    8'h04
`define ACS_OFF_SHT     8'h08
`define ACS_OFF_STAT    8'h0c
`define ACS_OFF_RESULT  8'h10
`define ACS_OFF_IRQ_ST  8'h14
`define ACS_OFF_IRQ_MSK 8'h18
`define ACS_OFF_ACM     8'h1c
// ==================================================================
// field positions
`define ACS_CTRL_GO     0
`define ACS_MODE_RES_LO 0
`define ACS_MODE_RES_HI 1
`define ACS_MODE_PCAL   3
`define ACS_EV_DONE     0
`define ACS_EV_SAT      1
// ==================================================================
// reset values
`define ACS_MODE_RST    4'h8
`define ACS_SHT_RST     8'h00
`define ACS_MSK_RST     2'h0
`define ACS_ACM_RST     32'h0000_0000
// ==================================================================
// resolution codes and bit counts
`define ACS_RES_10      2'h0
`define ACS_RES_8       2'h1
`define ACS_BITS_8      9'h008
`define ACS_BITS_10     9'h00a
`define ACS_BITS_12     9'h00c
`define ACS_RES_W       12
`define ACS_FULL        12'hfff
// ==================================================================
// timing: converter clock = system clock / ACS_DIV
`define ACS_DIV         8'h04
`define ACS_ACQ_BASE    9'h002
`define ACS_CAL_TICKS   9'h002
// ==================================================================
// bus responses
`define ACS_RESP_OK     2'h0
`define ACS_RESP_ERR    2'h2
`endif

// file: rtl/acs_pkg.sv
// types shared by the conversion sequencer
package acs_pkg;
    // sequencer phases
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_ACQ,
        ACS_DIST,
        ACS_CAL
    } acs_state_t;
endpackage

// file: rtl/acs_sequencer.sv
// conversion sequencer with axi4-lite registers and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module acs_sequencer (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`ACS_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [`ACS_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    input  wire logic                   conversion_go,
    input  wire logic [`ACS_RES_W-1:0]  analog_code,
    input  wire logic                   current_overrange,
    output logic                        busy,
    output logic                        sample,
    output logic                        result_ready,
    output logic [`ACS_RES_W-1:0]       result,
    output logic [31:0]                 quad_config,
    output logic                        quad_config_load,
    output logic                        irq
);
    // ==============================================================
    // state and registers
    acs_pkg::acs_state_t state;          // sequencer phase
    logic [3:0]  mode;                   // resolution and calibration
    logic [7:0]  sample_time_setting;    // sample_hold_length
    logic [1:0]  irq_status;             // sticky events
    logic [1:0]  irq_mask;               // enables onto irq
    logic [7:0]  div;                    // converter clock divider
    logic [8:0]  cnt;                    // ticks left in phase
    logic [8:0]  nbits_lat;              // resolution of this run
    logic        pcal_lat;               // calibration of this run
    logic        sat_lat;                // overrange seen at hold
    logic [`ACS_RES_W-1:0] held;         // held sample code
    logic [`ACS_RES_W-1:0] build;        // result under construction
    logic        go_q;                   // registered go pin
    logic        go_prev;                // for edge detection
    logic        go_wr;                  // go from ctrl register
    logic [`ACS_RES_W-1:0] code_s1;      // pin synchroniser stage 1
    logic [`ACS_RES_W-1:0] code_s2;      // pin synchroniser stage 2
    logic        ovr_s1;
    logic        ovr_s2;
    logic        aw_have;
    logic        w_have;
    logic [`ACS_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ==============================================================
    // decode and next values
    wire tick      = (div == `ACS_DIV - 8'h01);
    wire go_start  = (state == acs_pkg::ACS_IDLE) &&
                     ((go_q && !go_prev) || go_wr);
    wire last_tick = tick && (cnt == 9'h001);
    wire [1:0] res_sel = mode[`ACS_MODE_RES_HI:`ACS_MODE_RES_LO];
    wire [8:0] nbits = (res_sel == `ACS_RES_10) ? `ACS_BITS_10 :
                       (res_sel == `ACS_RES_8)  ? `ACS_BITS_8  :
                       `ACS_BITS_12;
    wire [3:0] shift = 4'(`ACS_RES_W) - nbits_lat[3:0];
    wire [`ACS_RES_W-1:0] full_scale = `ACS_FULL >> shift;
    wire [8:0] idx9  = cnt - 9'h001;
    wire [`ACS_RES_W-1:0] next_build =
        {build[`ACS_RES_W-2:0], held[idx9[3:0]]};
    wire dist_end  = (state == acs_pkg::ACS_DIST) && last_tick;
    wire cal_end   = (state == acs_pkg::ACS_CAL) && last_tick;
    wire conv_end  = (dist_end && !pcal_lat) || cal_end;
    // write side of the bus
    wire aw_hs     = awvalid && awready;
    wire w_hs      = wvalid && wready;
    wire do_write  = aw_have && w_have && !bvalid;
    wire next_aw_have = (aw_have || aw_hs) && !do_write;
    wire next_w_have  = (w_have || w_hs) && !do_write;
    wire next_bvalid  = do_write || (bvalid && !bready);
    wire wr_b0     = do_write && w_strb[0];
    wire wr_ctrl   = wr_b0 && (aw_addr == `ACS_OFF_CTRL);
    wire wr_mode   = wr_b0 && (aw_addr == `ACS_OFF_MODE);
    wire wr_sht    = wr_b0 && (aw_addr == `ACS_OFF_SHT);
    wire wr_ist    = wr_b0 && (aw_addr == `ACS_OFF_IRQ_ST);
    wire wr_msk    = wr_b0 && (aw_addr == `ACS_OFF_IRQ_MSK);
    wire wr_acm    = do_write && (aw_addr == `ACS_OFF_ACM);
    wire wr_map    = (aw_addr[1:0] == 2'h0) &&
                     (aw_addr <= `ACS_OFF_ACM);
    // read side of the bus
    wire ar_hs     = arvalid && arready;
    wire rd_map    = (araddr[1:0] == 2'h0) && (araddr <= `ACS_OFF_ACM);
    wire [31:0] rd_data =
        (araddr == `ACS_OFF_MODE)    ? {28'h0, mode} :
        (araddr == `ACS_OFF_SHT)     ? {24'h0, sample_time_setting} :
        (araddr == `ACS_OFF_STAT)    ? {28'h0, pcal_lat, result_ready,
                                        sample, busy} :
        (araddr == `ACS_OFF_RESULT)  ? {20'h0, result} :
        (araddr == `ACS_OFF_IRQ_ST)  ? {30'h0, irq_status} :
        (araddr == `ACS_OFF_IRQ_MSK) ? {30'h0, irq_mask} :
        (araddr == `ACS_OFF_ACM)     ? quad_config : 32'h0;
    // events: hardware set wins over a write-one clear
    wire [1:0] ev_set = {conv_end && sat_lat, conv_end};
    wire [1:0] next_irq_status =
        ev_set | (irq_status & ~(wr_ist ? w_data[1:0] : 2'h0));

    // ==============================================================
    // pin synchronisers, two flops before any use
    always_ff @(posedge aclk) begin
        code_s1 <= analog_code;
        code_s2 <= code_s1;
        ovr_s1  <= current_overrange;
        ovr_s2  <= ovr_s1;
    end

    // go pin is fabric logic on this clock: one register is the
    // input synchronisation stage of the latency budget
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            go_q    <= 1'b0;
            go_prev <= 1'b0;
            go_wr   <= 1'b0;
        end else begin
            go_q    <= conversion_go;
            go_prev <= go_q;
            go_wr   <= wr_ctrl && w_data[`ACS_CTRL_GO];
        end
    end

    // converter clock enable; restarted so each phase is whole ticks
    always_ff @(posedge aclk) begin
        if (!aresetn || go_start || tick) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    // ==============================================================
    // sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= acs_pkg::ACS_IDLE;
            cnt       <= 9'h000;
            nbits_lat <= `ACS_BITS_10;
            pcal_lat  <= 1'b0;
            sat_lat   <= 1'b0;
            held      <= '0;
            build     <= '0;
        end else begin
            case (state)
                acs_pkg::ACS_IDLE: begin
                    if (go_start) begin
                        // settings are frozen for the whole run
                        state     <= acs_pkg::ACS_ACQ;
                        cnt       <= `ACS_ACQ_BASE +
                                     {1'b0, sample_time_setting};
                        nbits_lat <= nbits;
                        pcal_lat  <= mode[`ACS_MODE_PCAL];
                        build     <= '0;
                    end
                end
                acs_pkg::ACS_ACQ: begin
                    if (last_tick) begin
                        state   <= acs_pkg::ACS_DIST;
                        cnt     <= nbits_lat;
                        sat_lat <= ovr_s2;
                        // overrange clamps rather than wraps
                        held    <= ovr_s2 ? full_scale
                                          : (code_s2 >> shift);
                    end else if (tick) begin
                        cnt <= cnt - 9'h001;
                    end
                end
                acs_pkg::ACS_DIST: begin
                    if (tick) begin
                        build <= next_build;
                    end
                    if (last_tick) begin
                        state <= pcal_lat ? acs_pkg::ACS_CAL
                                          : acs_pkg::ACS_IDLE;
                        cnt   <= `ACS_CAL_TICKS;
                    end else if (tick) begin
                        cnt <= cnt - 9'h001;
                    end
                end
                acs_pkg::ACS_CAL: begin
                    if (last_tick) begin
                        state <= acs_pkg::ACS_IDLE;
                    end else if (tick) begin
                        cnt <= cnt - 9'h001;
                    end
                end
                default: begin
                    state <= acs_pkg::ACS_IDLE;
                end
            endcase
        end
    end

    // ==============================================================
    // user-side status outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy         <= 1'b0;
            sample       <= 1'b0;
            result_ready <= 1'b0;
            result       <= '0;
        end else begin
            if (go_start) begin
                busy         <= 1'b1;
                sample       <= 1'b1;
                result_ready <= 1'b0;
            end
            if (state == acs_pkg::ACS_ACQ && last_tick) begin
                sample <= 1'b0;
            end
            if (conv_end) begin
                busy         <= 1'b0;
                result_ready <= 1'b1;
                // without calibration the last bit lands in the same edge as busy falls
                result       <= cal_end ? build : next_build;
            end
        end
    end

    // ==============================================================
    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // calibration on by default, as drift needs it
            mode                <= `ACS_MODE_RST;
            sample_time_setting <= `ACS_SHT_RST;
            irq_mask            <= `ACS_MSK_RST;
            irq_status          <= 2'h0;
            irq                 <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode <= w_data[3:0];
            end
            if (wr_sht) begin
                sample_time_setting <= w_data[7:0];
            end
            if (wr_msk) begin
                irq_mask <= w_data[1:0];
            end
            irq_status <= next_irq_status;
            irq        <= |(next_irq_status & irq_mask);
        end
    end

    // config manager word: byte lanes, usable while converting
    wire [31:0] acm_rst = `ACS_ACM_RST;  // reset word, split per lane
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_acm
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    quad_config[gb*8 +: 8] <= acm_rst[gb*8 +: 8];
                end else if (wr_acm && w_strb[gb]) begin
                    quad_config[gb*8 +: 8] <= w_data[gb*8 +: 8];
                end
            end
        end
    endgenerate

    // one-cycle load strobe tells the analog quads to switch context
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quad_config_load <= 1'b0;
        end else begin
            quad_config_load <= wr_acm && (|w_strb);
        end
    end

    // ==============================================================
    // axi4-lite write channel: address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `ACS_RESP_OK;
            aw_addr <= '0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end else begin
            aw_have <= next_aw_have;
            w_have  <= next_w_have;
            awready <= !next_aw_have && !next_bvalid;
            wready  <= !next_w_have && !next_bvalid;
            bvalid  <= next_bvalid;
            if (aw_hs) begin
                aw_addr <= awaddr;
            end
            if (w_hs) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (do_write) begin
                bresp <= wr_map ? `ACS_RESP_OK : `ACS_RESP_ERR;
            end
        end
    end

    // axi4-lite read channel: answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `ACS_RESP_OK;
        end else begin
            if (ar_hs) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_map ? rd_data : 32'h0;
                rresp   <= rd_map ? `ACS_RESP_OK : `ACS_RESP_ERR;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    // ==============================================================
    // checks: phase lengths counted in system cycles
    logic [15:0] ph_cyc;                 // cycles spent in this phase
    acs_pkg::acs_state_t st_prev;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_cyc  <= 16'h0;
            st_prev <= acs_pkg::ACS_IDLE;
        end else begin
            st_prev <= state;
            // the edge that entered the phase already counts as one
            // cycle, so the value seen at the phase's last edge is its
            // full length in system cycles
            ph_cyc  <= (state != st_prev) ? 16'h2 : ph_cyc + 16'h1;
        end
    end
    wire [15:0] acq_len = 16'({1'b0, sample_time_setting} +
                              `ACS_ACQ_BASE) * 16'(`ACS_DIV);

    default clocking acs_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_start;
        go_start;
    endsequence
    sequence s_armed;
        busy && sample && !result_ready;
    endsequence

    property p_acq_len;
        (state == acs_pkg::ACS_ACQ) && last_tick && !wr_sht
            |-> ph_cyc == acq_len;
    endproperty
    a_acq_len: assert property (p_acq_len)
        else $error("acquisition length wrong");

    property p_sample_fall;
        $fell(sample) |-> busy && state == acs_pkg::ACS_DIST;
    endproperty
    a_sample_fall: assert property (p_sample_fall)
        else $error("sample fell without busy");

    property p_dist_len;
        dist_end |-> ph_cyc == 16'(nbits_lat) * 16'(`ACS_DIV);
    endproperty
    a_dist_len: assert property (p_dist_len)
        else $error("distribution length wrong");

    property p_cal_len;
        cal_end |-> ph_cyc == 16'(`ACS_CAL_TICKS) * 16'(`ACS_DIV)
                    ##1 !busy;
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");

    property p_no_cal;
        dist_end && !pcal_lat |=> !busy && result_ready;
    endproperty
    a_no_cal: assert property (p_no_cal)
        else $error("busy held without calibration");

    property p_ready_rise;
        $fell(busy) |-> result_ready && $rose(result_ready);
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("result_ready not with busy fall");

    property p_ready_hold;
        result_ready && !go_start |=> result_ready;
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("result_ready dropped early");

    property p_go;
        s_start |=> s_armed ##1 busy [*2];
    endproperty
    a_go: assert property (p_go)
        else $error("go did not start conversion");

    property p_stable;
        result_ready && $past(result_ready) |-> $stable(result);
    endproperty
    a_stable: assert property (p_stable)
        else $error("result changed while ready");

    property p_sat;
        conv_end && sat_lat |=> result == full_scale;
    endproperty
    a_sat: assert property (p_sat)
        else $error("overrange not saturated");

endmodule
`default_nettype wire

// file: tb/acs_fabric_model.sv
// fabric-side model: start pin, sample code and overrange pins
`timescale 1ns/1ps
`default_nettype none
module acs_fabric_model (
    input  wire logic        aclk,
    input  wire logic        busy,
    output logic             conversion_go,
    output logic [11:0]      analog_code,
    output logic             current_overrange
);
    logic busy_q; // previous busy, for fall detect
    // ==============================================================
    // pins
    initial begin
        conversion_go = 1'b0;
        analog_code = 12'h000;
        current_overrange = 1'b0;
        busy_q = 1'b0;
    end
    // pins flip once a run ends, so a late resample shows as a change
    always @(posedge aclk) begin
        busy_q <= busy;
        if (busy_q && !busy) begin
            analog_code <= ~analog_code;
            current_overrange <= ~current_overrange;
        end
    end
    // set pins, optionally start; held three cycles on purpose, since
    // a held level must not start a second run
    task automatic start(input logic [11:0] code, input logic ovr,
                         input logic pin);
        @(posedge aclk);
        analog_code <= code;
        current_overrange <= ovr;
        conversion_go <= pin;
        repeat (3) @(posedge aclk);
        conversion_go <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/acs_sequencer_tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_cfg.svh"
module acs_sequencer_tb;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        conversion_go, current_overrange, busy, sample;
    logic        result_ready, quad_config_load, irq, busy_q, seen;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, quad_config, seed;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [11:0] analog_code, result, last_res, cnt_s, cnt_b;
    int          fails, samples_checked, i;
    logic [33:0] q_rd[$]; // expected {rresp, rdata}
    logic [1:0]  q_wr[$]; // expected bresp
    logic [35:0] q_cv[$]; // expected {sample len, busy len, result}
    acs_sequencer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .conversion_go(conversion_go),
        .analog_code(analog_code), .current_overrange(current_overrange),
        .busy(busy), .sample(sample), .result_ready(result_ready),
        .result(result), .quad_config(quad_config),
        .quad_config_load(quad_config_load), .irq(irq));
    acs_fabric_model fab (.aclk(aclk), .busy(busy),
        .conversion_go(conversion_go), .analog_code(analog_code),
        .current_overrange(current_overrange));
    // ==============================================================
    // clock, helpers
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==============================================================
    // bus master: payload held until each channel is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        // let an edge pass so bready never drops and rises at once
        @(posedge aclk);
        q_wr.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        // let an edge pass so rready never drops and rises at once
        @(posedge aclk);
        q_rd.push_back({er, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask
    // bounded wait for a busy level; a miss counts as a mismatch
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 1200 && busy !== lvl; k++) @(posedge aclk);
        chk("busy", 36'(lvl), 36'(busy));
    endtask
    // one conversion: note expected lengths and code, then start it
    task automatic conv(input logic [1:0] res, input logic pc,
                        input logic [7:0] st, input logic ovr,
                        input logic pin, input logic twice);
        logic [11:0] n, r;
        n = (res == 2'h0) ? 12'h00a : (res == 2'h1) ? 12'h008 : 12'h00c;
        r = (ovr ? 12'hfff : seed[11:0]) >> (12'h00c - n);
        q_cv.push_back({(12'h002 + st) << 2,
                        (12'h002 + st + n + {pc, 1'b0}) << 2, r});
        wr(`ACS_OFF_MODE, {28'h0, pc, 1'b0, res}, `ACS_RESP_OK);
        wr(`ACS_OFF_SHT, {24'h0, st}, `ACS_RESP_OK);
        fab.start(seed[11:0], ovr, pin);
        if (pin) chk("latency", 36'h1, 36'(busy));
        if (!pin) wr(`ACS_OFF_CTRL, 32'h1, `ACS_RESP_OK);
        wait_busy(1'b1);
        if (twice) fab.start(seed[11:0], ovr, 1'b1);
        wait_busy(1'b0);
        rd(`ACS_OFF_STAT, {28'h0, pc, 3'b100}, `ACS_RESP_OK);
        seed = lfsr(seed);
    endtask
    // ==============================================================
    // watcher: each answer against the oldest note
    always @(posedge aclk) begin
        if (bvalid && bready) chk("bresp", 36'(q_wr.pop_front()), 36'(bresp));
        if (rvalid && rready)
            chk("rdata", 36'(q_rd.pop_front()), 36'({rresp, rdata}));
        if (busy) cnt_b <= cnt_b + 12'h001;
        if (busy && sample) cnt_s <= cnt_s + 12'h001;
        if (busy && !busy_q)
            chk("go_ack", 36'h2, 36'({sample, result_ready}));
        if (!busy && busy_q) begin
            chk("conv", q_cv.pop_front(), {cnt_s, cnt_b, result});
            chk("ready", 36'h1, 36'(result_ready));
            last_res <= result;
            seen <= 1'b1;
            cnt_s <= 12'h000;
            cnt_b <= 12'h000;
        end else if (!busy && seen)
            chk("hold", 36'({1'b1, last_res}),
                36'({result_ready, result}));
        busy_q <= busy;
    end
    // hang guard, sized well beyond the longest sequence
    initial begin
        #480000;
        fails++;
        end_of_test;
    end
    // ==============================================================
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hf};
        {busy_q, seen, cnt_s, cnt_b, last_res} = 38'h0;
        {fails, samples_checked, seed} = {32'h0, 32'h0, 32'hdcfb};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ACS_OFF_MODE, 32'h8, `ACS_RESP_OK);
        rd(`ACS_OFF_SHT, 32'h0, `ACS_RESP_OK);
        rd(`ACS_OFF_STAT, 32'h0, `ACS_RESP_OK);
        rd(`ACS_OFF_IRQ_MSK, 32'h0, `ACS_RESP_OK);
        rd(`ACS_OFF_ACM, 32'h0, `ACS_RESP_OK);
        rd(8'h20, 32'h0, `ACS_RESP_ERR);
        wr(8'h06, 32'h1, `ACS_RESP_ERR);
        // all resolutions, calibration on and off, both start paths
        for (i = 0; i < 8; i++)
            conv(i[1:0], i[2], i == 5 ? 8'hff : seed[15:8] & {8{i[0]}},
                 1'b0, i[0], i == 2);
        chk("irq", 36'h0, 36'(irq));
        wr(`ACS_OFF_IRQ_MSK, 32'h3, `ACS_RESP_OK);
        repeat (2) @(posedge aclk);
        chk("irq", 36'h1, 36'(irq));
        rd(`ACS_OFF_IRQ_ST, 32'h1, `ACS_RESP_OK);
        conv(2'h2, 1'b0, 8'h04, 1'b1, 1'b1, 1'b0);
        rd(`ACS_OFF_IRQ_ST, 32'h3, `ACS_RESP_OK);
        wr(`ACS_OFF_IRQ_ST, 32'h3, `ACS_RESP_OK);
        repeat (2) @(posedge aclk);
        chk("irq", 36'h0, 36'(irq));
        // runtime rewrite of the config manager word
        wr(`ACS_OFF_ACM, seed, `ACS_RESP_OK);
        // load strobe is seen at the edge that answers the write
        chk("quad_config_load", 36'h1, 36'(quad_config_load));
        chk("quad_config", 36'(seed), 36'(quad_config));
        rd(`ACS_OFF_ACM, seed, `ACS_RESP_OK);
        end_of_test;
    end
endmodule
`default_nettype wire
